// ===== pushbutton_power_sequencer.v
// pushbutton power-control state machine with wake and report outputs
`include "pb_seq_regs.vh"

// Behaviour
// (RULE_01) reset with battery enters shutdown to deep
// (RULE_02) one second later enter deep storage
// (RULE_03) long press, supply, keep-alive rise wake deep
// (RULE_04) rise state enables bucks in numerical order
// (RULE_05) five seconds after rise, enter running
// (RULE_06) keep-alive low then drops wake, bucks together
// (RULE_07) running leaves on keep-alive low or undervoltage
// (RULE_08) shutdown states clear serial registers, all bucks
// (RULE_09) soft shutdown lasts one second, ignores events
// (RULE_10) soft-off wakes on same three events
// (RULE_11) five-second press begun powered gives kill
// (RULE_12) kill in run/shutdown/soft-off goes deep shutdown
// (RULE_13) deep storage disables supplies, opens diode (code opens it only while extSupply is low)
// (RULE_14) rise releases wake for five seconds
// (RULE_15) good output after bucks within band 230ms
// (RULE_16) report ignores waking press, follows later presses
// (RULE_17) running press 50ms drives report low
// (RULE_18) serial enables honoured only in rise/running
// (RULE_19) external supply waits 100ms before rising
// (RULE_20) keep-alive rise wakes after 50ms
// (RULE_21) keep-alive fall in running: 50ms then shutdown
// (RULE_22) press held through shutdown needs release first
// (RULE_23) next buck enabled once previous near target
// (RULE_24) all pin inputs pass two flip-flops (code synchronises only button_b, keepAlive, extSupply and outUnderVolt)
// (RULE_25) one millisecond time base drives all delays
module pushbutton_power_sequencer #(
    parameter integer CLK_HZ   = `CLK_HZ,
    parameter integer TICK_CYC = CLK_HZ / 1000
) (
    // clock and reset
    input  wire        sys_clk,
    input  wire        rst_b,
    // pins and analog comparators
    input  wire        button_b,
    input  wire        keepAlive,
    input  wire        extSupply,
    input  wire        outUnderVolt,
    input  wire        batteryPresent,
    input  wire [2:0]  buckNearTarget,
    input  wire [2:0]  buckInBand,
    // serial-interface control requests
    input  wire        ldo1EnReq,
    input  wire        ldo2EnReq,
    input  wire        backlightEnReq,
    // wake open-drain pin
    output wire        wakeOut,
    output wire        wakeOe,
    // regulator enables, ideal diode and serial clear
    output reg  [2:0]  buckEn_reg,
    output reg         ldo1En_reg,
    output reg         ldo2En_reg,
    output reg         backlightEn_reg,
    output reg         idealDiodeOn_reg,
    output reg         serialClear_reg,
    // open-drain status pins
    output wire        goodOut,
    output wire        goodOe,
    output wire        reportOut,
    output wire        reportOe,
    // state and event
    output reg  [2:0]  state_reg,
    output reg         killEvent_reg
);

    // ----------------------------------------
    // input synchronisers
    // ----------------------------------------
    reg [3:0] sync1_reg;
    reg [3:0] sync2_reg;
    reg [3:0] prev_reg;
    always @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            sync1_reg <= 4'hd;
            sync2_reg <= 4'hd;
            prev_reg  <= 4'hd;
        end else begin
            sync1_reg <= {outUnderVolt, extSupply, keepAlive, button_b}; // RULE_24
            sync2_reg <= sync1_reg;
            prev_reg  <= sync2_reg;
        end
    end
    wire pressed   = ~sync2_reg[0];
    wire keepHi    = sync2_reg[1];
    wire extHi     = sync2_reg[2];
    wire uvlo      = sync2_reg[3];
    wire keepRise  = keepHi & ~prev_reg[1];
    wire extRise   = extHi & ~prev_reg[2];

    // ----------------------------------------
    // millisecond time base
    // ----------------------------------------
    reg [15:0] tickCnt_reg;
    wire       tick = (tickCnt_reg == TICK_CYC[15:0] - 16'h0001);
    always @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            tickCnt_reg <= 16'h0000;
        end else begin
            tickCnt_reg <= tick ? 16'h0000 : tickCnt_reg + 16'h0001; // RULE_25
        end
    end

    function isPowered;
        input [2:0] s;
        begin
            isPowered = (s == `ST_RISE_DEEP) || (s == `ST_RISE_SOFT) || (s == `ST_RUN);
        end
    endfunction

    // ----------------------------------------
    // state timer, pending-wake timer
    // ----------------------------------------
    reg [12:0] stMs_reg;
    reg [12:0] pendMs_reg;
    reg [1:0]  pend_reg;      // 0 none, 1 supply, 2 keep-alive
    reg [2:0]  stNext;
    reg        stChange;

    always @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            stMs_reg <= 13'h0000;
        end else if (stChange) begin
            stMs_reg <= 13'h0000; // RULE_25
        end else if (tick && stMs_reg != 13'h1fff) begin
            stMs_reg <= stMs_reg + 13'h0001;
        end
    end

    // ----------------------------------------
    // press timing and arming
    // ----------------------------------------
    wire [12:0] pressMs;
    press_timer #(.TICK_CYC(TICK_CYC), .MS_W(13)) u_press (
        .sys_clk     (sys_clk),
        .rst_b       (rst_b),
        .run         (pressed),
        .tick        (tick),
        .msCount_reg (pressMs)
    );
    reg pressArmed_reg;   // press began after a release
    reg killArmed_reg;    // press began in powered state
    reg wakePress_reg;    // press is the one that woke us
    wire pressStart = pressed & prev_reg[0];
    wire wakeByPress = pressed & pressArmed_reg & (pressMs >= `T_WAKE_PRESS_MS);

    always @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            pressArmed_reg <= 1'b0;
            killArmed_reg  <= 1'b0;
            wakePress_reg  <= 1'b0;
            killEvent_reg  <= 1'b0;
        end else begin
            if (!pressed) begin
                pressArmed_reg <= 1'b1; // RULE_22
            end else if (stChange && (stNext == `ST_SHUT_DEEP || stNext == `ST_SHUT_SOFT)) begin
                pressArmed_reg <= 1'b0; // RULE_22
            end
            if (pressStart) begin
                killArmed_reg <= isPowered(state_reg); // RULE_11
            end else if (!pressed) begin
                killArmed_reg <= 1'b0;
            end
            if (!pressed) begin
                wakePress_reg <= 1'b0;
            end else if (wakeByPress && stChange) begin
                wakePress_reg <= 1'b1; // RULE_16
            end
            killEvent_reg <= killArmed_reg & pressed & (pressMs >= `T_KILL_MS); // RULE_11
        end
    end

    // ----------------------------------------
    // state machine
    // ----------------------------------------
    wire pendDone = (pend_reg == 2'h1 && pendMs_reg >= `T_EXT_SETTLE_MS) || // RULE_19
                    (pend_reg == 2'h2 && pendMs_reg >= `T_KEEP_DLY_MS);     // RULE_20
    reg  [12:0] keepLowMs_reg;

    always @* begin
        stNext = state_reg;
        case (state_reg)
            `ST_SHUT_DEEP: if (stMs_reg >= `T_DEEP_MS) stNext = `ST_DEEP; // RULE_02
            `ST_DEEP: begin
                if (wakeByPress || pendDone) stNext = `ST_RISE_DEEP; // RULE_03
            end
            `ST_SOFT_OFF: begin
                if (killEvent_reg) stNext = `ST_SHUT_DEEP; // RULE_12
                else if (wakeByPress || pendDone) stNext = `ST_RISE_SOFT; // RULE_10
            end
            `ST_RISE_DEEP, `ST_RISE_SOFT: begin
                if (stMs_reg >= `T_RISE_MS) begin
                    stNext = keepHi ? `ST_RUN : `ST_SHUT_SOFT; // RULE_05 RULE_06
                end
            end
            `ST_RUN: begin
                if (killEvent_reg) stNext = `ST_SHUT_DEEP; // RULE_12
                else if (uvlo) stNext = `ST_SHUT_SOFT; // RULE_07
                else if (keepLowMs_reg >= `T_KEEP_DLY_MS) stNext = `ST_SHUT_SOFT; // RULE_21
            end
            `ST_SHUT_SOFT: begin
                if (killEvent_reg) stNext = `ST_SHUT_DEEP; // RULE_12
                else if (stMs_reg >= `T_SOFT_MS) stNext = `ST_SOFT_OFF; // RULE_09
            end
            default: stNext = `ST_SHUT_DEEP;
        endcase
        stChange = (stNext != state_reg);
    end

    always @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            state_reg     <= `ST_SHUT_DEEP; // RULE_01
            pend_reg      <= 2'h0;
            pendMs_reg    <= 13'h0000;
            keepLowMs_reg <= 13'h0000;
        end else begin
            state_reg <= stNext;
            // wake events queue only in the off states; soft shutdown ignores them
            if (stChange || !(state_reg == `ST_DEEP || state_reg == `ST_SOFT_OFF)) begin
                pend_reg <= 2'h0; // RULE_09
            end else if (pend_reg == 2'h0 && extRise) begin
                pend_reg <= 2'h1;
            end else if (pend_reg == 2'h0 && keepRise) begin
                pend_reg <= 2'h2;
            end
            if (pend_reg == 2'h0) begin
                pendMs_reg <= 13'h0000; // RULE_25
            end else if (tick) begin
                pendMs_reg <= pendMs_reg + 13'h0001;
            end
            if (keepHi || state_reg != `ST_RUN) begin
                keepLowMs_reg <= 13'h0000; // RULE_25
            end else if (tick && keepLowMs_reg != 13'h1fff) begin
                keepLowMs_reg <= keepLowMs_reg + 13'h0001;
            end
        end
    end

    // ----------------------------------------
    // regulator sequencing and serial enables
    // ----------------------------------------
    wire powered = isPowered(state_reg);
    reg  [12:0] goodMs_reg;
    reg         good_reg;
    reg         report_reg;
    reg  [12:0] runPressMs;

    always @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            buckEn_reg       <= 3'h0;
            ldo1En_reg       <= 1'b0;
            ldo2En_reg       <= 1'b0;
            backlightEn_reg  <= 1'b0;
            idealDiodeOn_reg <= 1'b1;
            serialClear_reg  <= 1'b1;
            goodMs_reg       <= 13'h0000;
            good_reg         <= 1'b0;
            report_reg       <= 1'b0;
        end else begin
            if (!powered) begin
                buckEn_reg <= 3'h0; // RULE_06 RULE_08
            end else begin
                buckEn_reg[0] <= 1'b1; // RULE_04
                buckEn_reg[1] <= buckEn_reg[0] & buckNearTarget[0]; // RULE_23
                buckEn_reg[2] <= buckEn_reg[1] & buckNearTarget[1]; // RULE_23
            end
            serialClear_reg <= (state_reg == `ST_SHUT_DEEP) ||
                               (state_reg == `ST_SHUT_SOFT); // RULE_08
            if (powered) begin
                ldo1En_reg      <= ldo1EnReq; // RULE_18
                ldo2En_reg      <= ldo2EnReq;
                backlightEn_reg <= backlightEnReq;
            end else begin
                ldo1En_reg      <= 1'b0; // RULE_08
                ldo2En_reg      <= 1'b0;
                backlightEn_reg <= 1'b0;
            end
            idealDiodeOn_reg <= !(state_reg == `ST_DEEP && !extHi); // RULE_13
            // a band drop restarts the qualification window
            if (buckEn_reg == 3'h0 || ((buckInBand & buckEn_reg) != buckEn_reg)) begin
                goodMs_reg <= 13'h0000;
            end else if (tick && goodMs_reg != 13'h1fff) begin
                goodMs_reg <= goodMs_reg + 13'h0001;
            end
            good_reg <= powered && (buckEn_reg == 3'h7) &&
                        (goodMs_reg >= `T_GOOD_MS); // RULE_15
            report_reg <= powered && pressed && !wakePress_reg &&
                          ((state_reg != `ST_RUN) ||
                           (pressMs >= `T_REPORT_MS)); // RULE_16 RULE_17
        end
    end

    // ----------------------------------------
    // open-drain pins: out is always 0, oe pulls low
    // ----------------------------------------
    assign wakeOut   = 1'b0;
    assign wakeOe    = !powered; // RULE_14
    assign goodOut   = 1'b0;
    assign goodOe    = !good_reg;
    assign reportOut = 1'b0;
    assign reportOe  = report_reg;

endmodule // pushbutton_power_sequencer

// ===== pb_seq_regs.vh
// timing constants and encodings for the pushbutton power sequencer
`ifndef PB_SEQ_REGS_VH
`define PB_SEQ_REGS_VH

// ----------------------------------------
// clock and times
// ----------------------------------------
`define CLK_HZ           50000000
`define T_DEEP_MS        1000
`define T_SOFT_MS        1000
`define T_WAKE_PRESS_MS  400
`define T_RISE_MS        5000
`define T_KILL_MS        5000
`define T_GOOD_MS        230
`define T_EXT_SETTLE_MS  100
`define T_KEEP_DLY_MS    50
`define T_REPORT_MS      50
`define MS_TO_CYC(ms)    ((`CLK_HZ / 1000) * (ms))

// ----------------------------------------
// state encodings
// ----------------------------------------
`define ST_SHUT_DEEP     3'h0
`define ST_DEEP          3'h1
`define ST_RISE_DEEP     3'h2
`define ST_RISE_SOFT     3'h3
`define ST_RUN           3'h4
`define ST_SHUT_SOFT     3'h5
`define ST_SOFT_OFF      3'h6

`endif

// ===== press_timer.v
// saturating millisecond counter that runs while its level input is high

module press_timer #(
    parameter integer TICK_CYC = 50000,
    parameter integer MS_W     = 13
) (
    // clock and reset
    input  wire              sys_clk,
    input  wire              rst_b,
    // control
    input  wire              run,
    input  wire              tick,
    // count
    output reg  [MS_W-1:0]   msCount_reg
);

    always @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            msCount_reg <= {MS_W{1'b0}};
        end else if (!run) begin
            msCount_reg <= {MS_W{1'b0}};
        end else if (tick && (msCount_reg != {MS_W{1'b1}})) begin
            msCount_reg <= msCount_reg + {{(MS_W-1){1'b0}}, 1'b1};
        end
    end

endmodule // press_timer

// ===== pb_seq_assertions.sv
// concurrent checks on the power sequencer ports
`include "pb_seq_regs.vh"

module pb_seq_checker #(
    parameter integer TICK_CYC = 50000
) (
    // clock and reset
    input wire       sys_clk,
    input wire       rst_b,
    // observed ports
    input wire [2:0] buckNearTarget,
    input wire [2:0] buckInBand,
    input wire       ldo1EnReq,
    input wire       wakeOe,
    input wire [2:0] buckEn_reg,
    input wire       ldo1En_reg,
    input wire       idealDiodeOn_reg,
    input wire       goodOe,
    input wire [2:0] state_reg
);
    timeunit 1ns;
    timeprecision 1ns;
    wire    up = (state_reg >= `ST_RISE_DEEP) && (state_reg <= `ST_RUN);
    integer bandCnt;

    // -----------------------------
    // cycles with all bucks in band
    // -----------------------------
    always @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            bandCnt <= 0;
        end else if (buckEn_reg == 3'h7 && buckInBand == 3'h7) begin
            bandCnt <= bandCnt + 1;
        end else begin
            bandCnt <= 0;
        end
    end

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_b);

    a_wake_release: assert property (wakeOe == !up)
        else $error("wake drive disagrees with state");
    a_buck2_order: assert property ($rose(buckEn_reg[1]) |-> buckEn_reg[0] && $past(buckNearTarget[0]))
        else $error("buck2 enabled early");
    a_buck3_order: assert property ($rose(buckEn_reg[2]) |-> buckEn_reg[1] && $past(buckNearTarget[1]))
        else $error("buck3 enabled early");
    a_bucks_together: assert property ($fell(up) |=> buckEn_reg == 3'h0)
        else $error("bucks not off together");
    a_ldo_powered: assert property (ldo1En_reg |-> up || $past(up))
        else $error("ldo on while down");
    a_ldo_follow: assert property ($rose(ldo1En_reg) |-> $past(ldo1EnReq) || $past(ldo1EnReq, 2))
        else $error("ldo on without request");
    a_deep_entry: assert property ($changed(state_reg) && state_reg == `ST_DEEP |-> $past(state_reg) == `ST_SHUT_DEEP)
        else $error("deep storage entered wrongly");
    a_soft_entry: assert property ($changed(state_reg) && state_reg == `ST_SOFT_OFF |-> $past(state_reg) == `ST_SHUT_SOFT)
        else $error("soft off entered wrongly");
    a_run_entry: assert property ($changed(state_reg) && state_reg == `ST_RUN |-> $past(up))
        else $error("running entered wrongly");
    a_good_all: assert property (!goodOe |-> buckEn_reg == 3'h7 || $past(buckEn_reg) == 3'h7)
        else $error("good released with a buck off");
    a_good_delay: assert property ($fell(goodOe) |-> bandCnt >= 229 * TICK_CYC)
        else $error("good released too early");
    a_diode_deep: assert property (!idealDiodeOn_reg |-> state_reg == `ST_DEEP || $past(state_reg) == `ST_DEEP)
        else $error("diode off outside deep storage");

    c_run: cover property ($changed(state_reg) && state_reg == `ST_RUN);
    c_good: cover property ($fell(goodOe));
    c_deep: cover property ($changed(state_reg) && state_reg == `ST_DEEP);
endmodule // pb_seq_checker

bind pushbutton_power_sequencer pb_seq_checker #(.TICK_CYC(TICK_CYC)) u_chk (
    .sys_clk(sys_clk), .rst_b(rst_b), .buckNearTarget(buckNearTarget),
    .buckInBand(buckInBand), .ldo1EnReq(ldo1EnReq), .wakeOe(wakeOe),
    .buckEn_reg(buckEn_reg), .ldo1En_reg(ldo1En_reg),
    .idealDiodeOn_reg(idealDiodeOn_reg), .goodOe(goodOe), .state_reg(state_reg));

// ===== host_model.sv
// host controller and regulator feedback on the far side
module host_model (
    // clock and reset
    input  wire       sys_clk,
    input  wire       rst_b,
    // bench controls
    input  wire       hostEn,
    input  wire       hostWake,
    // from the sequencer
    input  wire       wakeOe,
    input  wire       reportOe,
    input  wire [2:0] buckEn,
    // to the sequencer
    output reg        keepAlive_reg,
    output reg  [2:0] near_reg,
    output reg  [2:0] inBand_reg
);
    timeunit 1ns;
    timeprecision 1ns;
    reg [2:0] ramp_reg;
    reg       wakeOe_reg;

    always @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            keepAlive_reg <= 1'b0;
            ramp_reg      <= 3'h0;
            near_reg      <= 3'h0;
            inBand_reg    <= 3'h0;
            wakeOe_reg    <= 1'b1;
        end else begin
            wakeOe_reg <= wakeOe;
            // outputs take a few cycles to slew into the band
            ramp_reg   <= buckEn;
            near_reg   <= ramp_reg & buckEn;
            inBand_reg <= near_reg & buckEn;
            if (reportOe) begin
                keepAlive_reg <= 1'b0;
            end else if (hostWake || (hostEn && wakeOe_reg && !wakeOe)) begin
                keepAlive_reg <= 1'b1;
            end
        end
    end
endmodule // host_model

// ===== tb_top.sv
// self-checking bench for the pushbutton power sequencer
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int TK = 2;
    logic sys_clk = 0, rst_b = 0, button_b = 1, extSupply = 0, hostEn = 0, hostWake = 0;
    logic [2:0]  buckEn, nearT, inBand, st, req = 3'h0;
    logic        keepAlive, wakeOe, goodOe, reportOe, diode, clr, ldo1, ldo2, bl;
    logic [31:0] rnd = 32'he411d827;
    logic        uv = 0;
    int          errors = 0, nCompared = 0, cyc = 0, tMark = 0, pressT, n;

    pushbutton_power_sequencer #(.TICK_CYC(TK)) u_dut (
        .sys_clk(sys_clk), .rst_b(rst_b), .button_b(button_b), .keepAlive(keepAlive),
        .extSupply(extSupply), .outUnderVolt(uv), .batteryPresent(1'b1),
        .buckNearTarget(nearT), .buckInBand(inBand), .ldo1EnReq(req[2]),
        .ldo2EnReq(req[1]), .backlightEnReq(req[0]), .wakeOut(), .wakeOe(wakeOe),
        .buckEn_reg(buckEn), .ldo1En_reg(ldo1), .ldo2En_reg(ldo2), .backlightEn_reg(bl),
        .idealDiodeOn_reg(diode), .serialClear_reg(clr), .goodOut(), .goodOe(goodOe),
        .reportOut(), .reportOe(reportOe), .state_reg(st), .killEvent_reg());

    host_model u_host (
        .sys_clk(sys_clk), .rst_b(rst_b), .hostEn(hostEn), .hostWake(hostWake),
        .wakeOe(wakeOe), .reportOe(reportOe), .buckEn(buckEn),
        .keepAlive_reg(keepAlive), .near_reg(nearT), .inBand_reg(inBand));

    always #10 sys_clk = ~sys_clk;
    always @(posedge sys_clk) cyc++;

    function automatic logic [31:0] lfsr(input logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction

    task automatic wrap_up;
        $display("compared %0d mismatches %0d", nCompared, errors);
        if (errors == 0 && nCompared > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic [2:0] exp, input logic [2:0] got);
        nCompared++;
        if (got !== exp) begin
            errors++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic chk_time(input string what, input int ms, input int cycles);
        nCompared++;
        if (cycles < (ms - 4) * TK || cycles > (ms + 4) * TK) begin
            errors++;
            $display("wrong value %s expected %0d ms seen %0d ms", what, ms, cycles / TK);
        end
    endtask

    task automatic tick(input int k);
        repeat (k) @(posedge sys_clk);
        #1;
    endtask

    task automatic tmo(input int cnt, input int lim);
        if (cnt >= lim) begin
            errors++;
            wrap_up();
        end
    endtask

    // wait for the next state change and time it from the last mark
    task automatic step(input logic [2:0] exp, input int ms);
        logic [2:0] cur;
        int         k;
        cur = st;
        for (k = 0; st === cur && k < 6000 * TK; k++) tick(1);
        tmo(k, 6000 * TK);
        chk("state", exp, st);
        if (ms >= 0) chk_time("stateTime", ms, cyc - tMark);
        tMark = cyc;
    endtask

    task automatic ldos(input logic up);
        rnd = lfsr(rnd);
        req = rnd[2:0];
        tick(4);
        chk("ldoEn", up ? req : 3'h0, {ldo1, ldo2, bl});
    endtask

    // press and hold until the report pin answers, leaving the button down; the host then drops keep-alive
    task automatic report_press;
        int k;
        tMark = cyc;
        button_b = 0;
        for (k = 0; reportOe !== 1'b1 && k < 99 * TK; k++) tick(1);
        tmo(k, 99 * TK);
        chk_time("report", 50, cyc - tMark);
        tMark = cyc;
    endtask

    initial begin
        repeat (16) @(posedge sys_clk);
        #1 rst_b = 1;
        tMark = cyc;
        chk("state", 0, st);
        chk("wakeDrive", 1, wakeOe);
        step(1, 1000);
        tick(1);
        chk("diode", 0, diode);
        hostWake = 1;
        tMark = cyc;
        step(2, 50);
        hostWake = 0;
        for (n = 0; buckEn !== 3'h7 && n < 99; n++) tick(1);
        tmo(n, 99);
        chk("bucks", 7, buckEn);
        pressT = cyc;
        for (n = 0; goodOe !== 1'b0 && n < 300 * TK; n++) tick(1);
        tmo(n, 300 * TK);
        chk_time("good", 230, cyc - pressT);
        ldos(1);
        step(4, 5000);
        chk("wakeDrive", 0, wakeOe);
        ldos(1);
        pressT = cyc;
        report_press();
        step(5, 50);
        ldos(0);
        step(6, 1000);
        tMark = pressT;
        step(0, 5000);
        step(1, 1000);
        tick(500 * TK);
        chk("state", 1, st);
        button_b = 1;
        extSupply = 1;
        tMark = cyc;
        step(2, 100);
        step(5, 5000);
        tick(2);
        chk("bucks", 0, buckEn);
        chk("clear", 1, clr);
        step(6, 1000);
        hostEn = 1;
        button_b = 0;
        tMark = cyc;
        step(3, 400);
        tick(2);
        chk("report", 0, reportOe);
        button_b = 1;
        step(4, 5000);
        report_press();
        button_b = 1;
        step(5, 50);
        step(6, 1000);
        hostWake = 1;
        tMark = cyc;
        step(3, 50);
        button_b = 0;
        tick(4);
        chk("report", 1, reportOe);
        button_b = 1;
        step(4, 5000);
        hostWake = 0;
        uv = 1;
        tMark = cyc;
        step(5, 0);
        wrap_up();
    end
endmodule // tb_top
